// >>> rtl/vrcc_top.sv
// Operation
// - source bit picks pin or supply reference
// - bias enable forced by adc, sensor, oscillator
// - buffer enable drives reference onto pin
// - level bit picks one of two levels
// - sensor on when set, else high impedance
// - top two reference bits read zero
// - zero-tc bias auto when clear, forced set
// - synchronous and raw comparator outputs
// - input select holds two 4-bit fields
// - disabled comparator pin output held low
// - result readable, interrupt and wake source
// - comparator enable, resets to zero
// - edge flags latch until software writes zero
// - positive hysteresis code selects magnitude
// - negative hysteresis code selects magnitude
// - comparator output offered as reset source
module vrcc_top
  import vrcc_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic ADC_EN_I,
  input wire logic OSC_EN_I,
  input wire logic CMP_ANALOG_I,
  output logic REF_SOURCE_SELECT_O,
  output logic BIAS_GEN_ENABLE_O,
  output logic REF_BUFFER_ENABLE_O,
  output logic REF_LEVEL_SELECT_O,
  output logic TEMP_SENSOR_ENABLE_O,
  output logic TEMP_SENSOR_OE_O,
  output logic ZERO_TC_BIAS_FORCE_O,
  output logic CMP_ENABLE_O,
  output logic [1:0] CMP_POS_HYST_O,
  output logic [1:0] CMP_NEG_HYST_O,
  output logic CMP_POS_HYST_EN_O,
  output logic CMP_NEG_HYST_EN_O,
  output logic [3:0] CMP_POS_INPUT_SEL_O,
  output logic [3:0] CMP_NEG_INPUT_SEL_O,
  output logic CMP_SYNC_OUT_O,
  output logic CMP_RAW_OUT_O,
  output logic CMP_RISE_FLAG_O,
  output logic CMP_FALL_FLAG_O,
  output logic CMP_IRQ_O,
  output logic CMP_WAKE_O,
  output logic CMP_RESET_SRC_O
);
  // ****************************************
  // register storage
  // ****************************************
  logic [5:0] ref_ctrl_q;
  logic cmp_en_q;
  vrcc_hyst_t pos_hyst_q;
  vrcc_hyst_t neg_hyst_q;
  logic [7:0] insel_q;
  logic cmp_sync;
  logic cmp_prev_q;
  logic rise_flag;
  logic fall_flag;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  logic wr_ref;
  logic wr_cmp;
  logic wr_insel;
  assign wr_ref = REG_WR_I && hit(REG_ADDR_I, REF_CTRL_ADDR);
  assign wr_cmp = REG_WR_I && hit(REG_ADDR_I, CMP_CTRL_ADDR);
  assign wr_insel = REG_WR_I && hit(REG_ADDR_I, CMP_INSEL_ADDR);

  // the reserved pair is never stored, so it can only read back as zero
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ref_ctrl_q <= REF_CTRL_RST[5:0];
    end else if (wr_ref) begin
      ref_ctrl_q <= REG_WDATA_I[5:0];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cmp_en_q <= CMP_CTRL_RST[CMP_EN_BIT];
      pos_hyst_q <= VRCC_HYST_OFF;
      neg_hyst_q <= VRCC_HYST_OFF;
    end else if (wr_cmp) begin
      cmp_en_q <= REG_WDATA_I[CMP_EN_BIT];
      pos_hyst_q <= vrcc_hyst_t'(REG_WDATA_I[CMP_HYP_LSB +: 2]);
      neg_hyst_q <= vrcc_hyst_t'(REG_WDATA_I[CMP_HYN_LSB +: 2]);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      insel_q <= CMP_INSEL_RST;
    end else if (wr_insel) begin
      insel_q <= REG_WDATA_I;
    end
  end

  // ****************************************
  // comparator result path
  // ****************************************
  logic cmp_gated;
  assign cmp_gated = cmp_en_q & CMP_ANALOG_I;

  vrcc_sync u_sync (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .d_i(cmp_gated),
    .q_o(cmp_sync)
  );

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_prev_q <= cmp_sync;
    end
  end

  logic rise_evt;
  logic fall_evt;
  logic clr_rise;
  logic clr_fall;
  assign rise_evt = cmp_sync & ~cmp_prev_q;
  assign fall_evt = ~cmp_sync & cmp_prev_q;
  assign clr_rise = wr_cmp & ~REG_WDATA_I[CMP_RISE_BIT];
  assign clr_fall = wr_cmp & ~REG_WDATA_I[CMP_FALL_BIT];

  vrcc_edge_flag u_rise (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .set_i(rise_evt),
    .clr_i(clr_rise),
    .flag_o(rise_flag)
  );

  vrcc_edge_flag u_fall (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .set_i(fall_evt),
    .clr_i(clr_fall),
    .flag_o(fall_flag)
  );

  // ****************************************
  // read port
  // ****************************************
  always_comb begin
    rdata_d = 8'h00;
    if (hit(REG_ADDR_I, REF_CTRL_ADDR)) begin
      rdata_d = {2'h0, ref_ctrl_q};
    end else if (hit(REG_ADDR_I, CMP_CTRL_ADDR)) begin
      rdata_d = {cmp_en_q, cmp_sync, rise_flag, fall_flag, pos_hyst_q, neg_hyst_q};
    end else if (hit(REG_ADDR_I, CMP_INSEL_ADDR)) begin
      rdata_d = insel_q;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_q <= 8'h00;
    end else if (REG_RD_I) begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // analog control outputs
  // ****************************************
  assign REG_RDATA_O = rdata_q;
  assign REF_SOURCE_SELECT_O = ref_ctrl_q[REF_SRC_BIT];
  assign BIAS_GEN_ENABLE_O = ref_ctrl_q[BIAS_EN_BIT] | ADC_EN_I | OSC_EN_I
                             | ref_ctrl_q[TEMP_EN_BIT];
  assign REF_BUFFER_ENABLE_O = ref_ctrl_q[REF_BUF_EN_BIT];
  // level polarity awaits confirmation; the bit is passed through as stored
  assign REF_LEVEL_SELECT_O = ref_ctrl_q[REF_LVL_BIT];
  assign TEMP_SENSOR_ENABLE_O = ref_ctrl_q[TEMP_EN_BIT];
  assign TEMP_SENSOR_OE_O = ref_ctrl_q[TEMP_EN_BIT];
  assign ZERO_TC_BIAS_FORCE_O = ref_ctrl_q[ZTC_EN_BIT];
  assign CMP_ENABLE_O = cmp_en_q;
  assign CMP_POS_HYST_O = pos_hyst_q;
  assign CMP_NEG_HYST_O = neg_hyst_q;
  assign CMP_POS_HYST_EN_O = pos_hyst_q != VRCC_HYST_OFF;
  assign CMP_NEG_HYST_EN_O = neg_hyst_q != VRCC_HYST_OFF;
  assign CMP_POS_INPUT_SEL_O = insel_q[CMP_POS_SEL_LSB +: 4];
  assign CMP_NEG_INPUT_SEL_O = insel_q[CMP_NEG_SEL_LSB +: 4];
  // raw path has no flop so it keeps working with the clock stopped
  assign CMP_RAW_OUT_O = cmp_gated;
  assign CMP_SYNC_OUT_O = cmp_sync;
  assign CMP_RISE_FLAG_O = rise_flag;
  assign CMP_FALL_FLAG_O = fall_flag;
  assign CMP_IRQ_O = rise_flag | fall_flag;
  assign CMP_WAKE_O = cmp_gated;
  assign CMP_RESET_SRC_O = cmp_sync;

  // ****************************************
  // checks
  // ****************************************
  a_rise_flag_set: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (cmp_sync && !cmp_prev_q) |=> rise_flag)
    else $error("rise edge not flagged");
  a_fall_flag_set: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (!cmp_sync && cmp_prev_q) |=> fall_flag)
    else $error("fall edge not flagged");
  a_flag_hold: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (rise_flag && !wr_cmp) |=> rise_flag)
    else $error("rise flag dropped");
  a_fall_hold: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (fall_flag && !wr_cmp) |=> fall_flag)
    else $error("fall flag dropped");
  // a clear only wins when no fresh edge arrives in the same cycle
  a_rise_clear: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (wr_cmp && !REG_WDATA_I[CMP_RISE_BIT] && !rise_evt) |=> !rise_flag)
    else $error("rise flag not cleared");
  a_sync_two_stage: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    $rose(cmp_gated) ##1 cmp_gated |=> cmp_sync)
    else $error("sync latency wrong");
  a_disabled_low: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    !cmp_en_q |-> !CMP_RAW_OUT_O)
    else $error("disabled output not low");
  // the latched pin output needs the two synchroniser stages to drain
  a_sync_low_off: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    $fell(cmp_en_q) |-> ##2 !CMP_SYNC_OUT_O)
    else $error("latched output not low");
  a_bias_forced: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (ADC_EN_I || OSC_EN_I || TEMP_SENSOR_ENABLE_O) |-> BIAS_GEN_ENABLE_O)
    else $error("bias not forced");
  a_bias_manual: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (wr_ref && REG_WDATA_I[BIAS_EN_BIT]) |=> BIAS_GEN_ENABLE_O)
    else $error("bias not set by write");
  a_src_write: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_ref |=> REF_SOURCE_SELECT_O == $past(REG_WDATA_I[REF_SRC_BIT]))
    else $error("source select not written");
  a_buf_write: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_ref |=> REF_BUFFER_ENABLE_O == $past(REG_WDATA_I[REF_BUF_EN_BIT]))
    else $error("buffer enable not written");
  a_level_write: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_ref |=> REF_LEVEL_SELECT_O == $past(REG_WDATA_I[REF_LVL_BIT]))
    else $error("level select not written");
  a_sensor_write: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_ref |=> TEMP_SENSOR_ENABLE_O == $past(REG_WDATA_I[TEMP_EN_BIT]))
    else $error("sensor enable not written");
  a_sensor_hiz: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    !TEMP_SENSOR_ENABLE_O |-> !TEMP_SENSOR_OE_O)
    else $error("sensor output driven while off");
  a_ztc_write: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_ref |=> ZERO_TC_BIAS_FORCE_O == $past(REG_WDATA_I[ZTC_EN_BIT]))
    else $error("zero-tc force not written");
  a_ref_reserved: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (REG_RD_I && hit(REG_ADDR_I, REF_CTRL_ADDR)) |=> REG_RDATA_O[7:6] == 2'h0)
    else $error("reserved bits nonzero");
  a_insel_write: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_insel |=> {CMP_POS_INPUT_SEL_O, CMP_NEG_INPUT_SEL_O} == $past(REG_WDATA_I))
    else $error("input select not written");
  a_enable_write: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_cmp |=> CMP_ENABLE_O == $past(REG_WDATA_I[CMP_EN_BIT]))
    else $error("enable not written");
  a_out_state_ro: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (REG_RD_I && hit(REG_ADDR_I, CMP_CTRL_ADDR)) |=> REG_RDATA_O[CMP_OUT_BIT] == $past(cmp_sync))
    else $error("output state mismatch");
  a_irq_on_edge: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (cmp_sync != cmp_prev_q) |=> CMP_IRQ_O)
    else $error("edge raised no interrupt");
  a_wake_raw: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (cmp_en_q && CMP_ANALOG_I) |-> CMP_WAKE_O)
    else $error("wake source missing");
  // the reset source lags the gated decision by the two synchroniser stages
  a_reset_src: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    CMP_RESET_SRC_O == $past(cmp_gated, 2))
    else $error("reset source wrong");
  a_pos_hyst_write: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_cmp |=> CMP_POS_HYST_O == $past(REG_WDATA_I[CMP_HYP_LSB +: 2]))
    else $error("positive hysteresis not written");
  a_neg_hyst_write: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_cmp |=> CMP_NEG_HYST_O == $past(REG_WDATA_I[CMP_HYN_LSB +: 2]))
    else $error("negative hysteresis not written");
  a_hyst_zero: assert property (
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (pos_hyst_q == VRCC_HYST_OFF) |-> !CMP_POS_HYST_EN_O)
    else $error("hysteresis not off");
endmodule

// >>> rtl/vrcc_pkg.sv
package vrcc_pkg;
  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] CMP_CTRL_ADDR = 8'h9b;
  localparam logic [7:0] REF_CTRL_ADDR = 8'hd1;
  localparam logic [7:0] CMP_INSEL_ADDR = 8'h9f;
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_INSEL_RST = 8'h00;

  // ****************************************
  // reference control fields
  // ****************************************
  localparam int REF_BUF_EN_BIT = 0;
  localparam int BIAS_EN_BIT = 1;
  localparam int TEMP_EN_BIT = 2;
  localparam int REF_SRC_BIT = 3;
  localparam int REF_LVL_BIT = 4;
  localparam int ZTC_EN_BIT = 5;
  localparam logic [7:0] REF_CTRL_WMASK = 8'h3f;

  // ****************************************
  // comparator control fields
  // ****************************************
  localparam int CMP_EN_BIT = 7;
  localparam int CMP_OUT_BIT = 6;
  localparam int CMP_RISE_BIT = 5;
  localparam int CMP_FALL_BIT = 4;
  localparam int CMP_HYP_LSB = 2;
  localparam int CMP_HYN_LSB = 0;
  localparam int CMP_POS_SEL_LSB = 4;
  localparam int CMP_NEG_SEL_LSB = 0;

  // hysteresis codes; 00 means hysteresis off
  typedef enum logic [1:0] {
    VRCC_HYST_OFF = 2'h0,
    VRCC_HYST_5MV = 2'h1,
    VRCC_HYST_10MV = 2'h2,
    VRCC_HYST_MAX = 2'h3
  } vrcc_hyst_t;
endpackage

// >>> rtl/vrcc_sync.sv
module vrcc_sync
  import vrcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// >>> rtl/vrcc_edge_flag.sv
module vrcc_edge_flag
  import vrcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_q;

  // a set in the same cycle as a clear wins, so no edge is lost
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;
endmodule

// >>> verif/vref_comparator_control_tb.sv
module vref_comparator_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vrcc_pkg::*;

  // ****************************************
  // stimulus and design hookup
  // ****************************************
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [7:0] r;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic adc = 1'b0;
  logic osc = 1'b0;
  logic ana = 1'b0;
  logic src, bias, rbuf, lvl, temp, toe, ztc, cen, phen, nhen;
  logic sync, raw, rise, fall, irq, wake, rsrc;
  logic [1:0] ph;
  logic [1:0] nh;
  logic [3:0] ps;
  logic [3:0] ns;
  logic [31:0] rnd;
  int miscompares = 0;
  int checks_done = 0;
  int seed = 32'ha3bc3369;

  always #2.5 clk = ~clk;

  vrcc_top uut (
    .CLK_SYS_I(clk), .ARST_N_I(arst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .ADC_EN_I(adc), .OSC_EN_I(osc),
    .CMP_ANALOG_I(ana), .REF_SOURCE_SELECT_O(src), .BIAS_GEN_ENABLE_O(bias),
    .REF_BUFFER_ENABLE_O(rbuf), .REF_LEVEL_SELECT_O(lvl), .TEMP_SENSOR_ENABLE_O(temp),
    .TEMP_SENSOR_OE_O(toe), .ZERO_TC_BIAS_FORCE_O(ztc), .CMP_ENABLE_O(cen),
    .CMP_POS_HYST_O(ph), .CMP_NEG_HYST_O(nh), .CMP_POS_HYST_EN_O(phen),
    .CMP_NEG_HYST_EN_O(nhen), .CMP_POS_INPUT_SEL_O(ps), .CMP_NEG_INPUT_SEL_O(ns),
    .CMP_SYNC_OUT_O(sync), .CMP_RAW_OUT_O(raw), .CMP_RISE_FLAG_O(rise),
    .CMP_FALL_FLAG_O(fall), .CMP_IRQ_O(irq), .CMP_WAKE_O(wake), .CMP_RESET_SRC_O(rsrc)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic bias_f(logic [7:0] c, logic a, logic o);
    return c[1] | c[2] | a | o;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // read data is registered, so look one edge after the strobe is taken
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp_step(input logic a, input logic [7:0] exp);
    @(posedge clk);
    ana <= a;
    repeat (4) @(posedge clk);
    #1 chk({3'h0, sync, rise, fall, irq, rsrc}, exp);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rreg(REF_CTRL_ADDR, r);
    chk(r, REF_CTRL_RST);
    rreg(CMP_CTRL_ADDR, r);
    chk(r, CMP_CTRL_RST);
    rreg(CMP_INSEL_ADDR, r);
    chk(r, CMP_INSEL_RST);
    for (int i = 0; i < 24; i++) begin
      rnd = $random(seed);
      v = (i == 0) ? 8'hff : (i == 1) ? 8'hc0 : rnd[7:0];
      @(posedge clk);
      adc <= rnd[8];
      osc <= rnd[9];
      wreg(REF_CTRL_ADDR, v);
      // buffer, source, level, sensor, sensor drive and zero-tc outputs are seen here
      chk({2'h0, ztc, lvl, src, temp, toe, rbuf}, {2'h0, v[5:2], v[2], v[0]});
      chk({7'h00, bias}, {7'h00, bias_f(v, adc, osc)});
      rreg(REF_CTRL_ADDR, r);
      chk(r, v & REF_CTRL_WMASK);
    end
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      wreg(CMP_INSEL_ADDR, rnd[7:0]);
      chk({ps, ns}, rnd[7:0]);
      rreg(CMP_INSEL_ADDR, r);
      chk(r, rnd[7:0]);
    end
    wreg(8'h55, 8'hff);
    rreg(8'h55, r);
    chk(r, 8'h00);
    for (int i = 0; i < 16; i++) begin
      v = 8'(i);
      wreg(CMP_CTRL_ADDR, v);
      chk({2'h0, phen, nhen, ph, nh}, {2'h0, |v[3:2], |v[1:0], v[3:0]});
      rreg(CMP_CTRL_ADDR, r);
      chk(r, v);
    end
    wreg(CMP_CTRL_ADDR, 8'h80);
    chk({7'h00, cen}, 8'h01);
    @(posedge clk);
    ana <= 1'b1;
    #1 chk({6'h00, raw, wake}, 8'h03);
    @(posedge clk);
    #1 chk({7'h00, sync}, 8'h00);
    @(posedge clk);
    #1 chk({7'h00, sync}, 8'h01);
    @(posedge clk);
    #1 chk({3'h0, sync, rise, fall, irq, rsrc}, 8'h1b);
    rreg(CMP_CTRL_ADDR, r);
    chk(r, 8'ha0 | 8'h40);
    wreg(CMP_CTRL_ADDR, 8'hf0);
    rreg(CMP_CTRL_ADDR, r);
    chk(r, 8'he0);
    cmp_step(1'b0, 8'h0e);
    wreg(CMP_CTRL_ADDR, 8'h80);
    chk({5'h00, rise, fall, irq}, 8'h00);
    cmp_step(1'b1, 8'h1b);
    wreg(CMP_CTRL_ADDR, 8'h00);
    chk({6'h00, raw, cen}, 8'h00);
    cmp_step(1'b1, 8'h06);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule
